// *** rtl/pdm_ctrl.sv ***
// power-down mode controller with apb register access
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module pdm_ctrl (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset,
	input  wire logic                manual_reset,
	// apb
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// cpu side
	input  wire logic                sleep_exec,
	input  wire logic                block_bit,
	input  wire logic [3:0]          irq_mask_level,
	input  wire logic                nmi_req,
	input  wire logic [3:0]          encoded_level_irq,
	input  wire logic                port_irq,
	input  wire logic                periph_irq,
	input  wire logic                rtc_irq,
	input  wire logic [3:0]          periph_level,
	input  wire logic [11:0]         periph_code,
	input  wire logic                rtc_in_use,
	input  wire logic                refresh_active,
	input  wire logic                sub_clk_tick,
	input  wire logic                hw_standby_request_n,
	output logic                     cpu_halt,
	output logic                     irq_take,
	output logic                     bus_clk_en,
	output logic                     periph_clk_en,
	output logic                     timer_unit_clk_en,
	output logic                     calendar_clk_en,
	output logic                     serial0_clk_en,
	output logic                     bus_ctrl_clk_en,
	output logic                     timer_start_clr,
	output logic                     calendar_access_ok,
	output logic                     serial0_reset,
	// state pins
	output logic                     proc_state_hi,
	output logic                     proc_state_lo
);
	import pdm_pkg::*;

	pdm_state_t  state_q, state_d;
	logic [7:0]  power_down_control_reg_q;
	logic [7:0]  ctrl2_q;
	logic [7:0]  watchdog_counter_q;
	logic [11:0] event_code_reg_q, event_code_reg_b_q;
	logic [1:0]  sub_lows_q;
	logic        wake, wake_lvl, wake_ext, wake_per, wr_acc, rd_acc;
	logic [11:0] wake_code;
	logic [1:0]  pins_d;
	logic        hw_req, stopped, rearm_q;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign hw_req = (sub_lows_q == 2'(PDM_SUB_LOWS));

	// wake sources; block bit is deliberately not consulted
	always_comb begin
		wake_lvl = (encoded_level_irq != 4'h0) && (encoded_level_irq > irq_mask_level);
		wake_per = periph_irq && (periph_level > irq_mask_level);
		wake_ext = port_irq && (periph_level > irq_mask_level);
		if (state_q == PDM_STANDBY) begin
			wake = nmi_req | (rtc_in_use & (wake_lvl | wake_ext))
				| (rtc_irq & (periph_level > irq_mask_level));
		end else begin
			wake = nmi_req | wake_lvl | wake_per;
		end
		if (nmi_req)
			wake_code = PDM_EVT_NMI;
		else if (wake_lvl)
			wake_code = {4'h2, encoded_level_irq, 4'h0};
		else
			wake_code = periph_code;
	end

	// two low samples on the sub-clock make a hardware standby request
	always_ff @(posedge ref_clk) begin
		if (reset)
			sub_lows_q <= 2'b00;
		else if (sub_clk_tick)
			sub_lows_q <= hw_standby_request_n ? 2'b00 : (hw_req ? sub_lows_q : sub_lows_q + 2'b01);
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PDM_RUN: begin
				if (sleep_exec)
					state_d = power_down_control_reg_q[PDM_STANDBY_SELECT_BIT] ? PDM_STANDBY : PDM_SLEEP;
			end
			PDM_SLEEP:   if (wake) state_d = PDM_RUN;
			PDM_STANDBY: if (wake) state_d = PDM_SETTLE;
			PDM_SETTLE:  if (watchdog_counter_q == PDM_WDT_TOP) state_d = PDM_RUN;
			PDM_LOCKED:  state_d = PDM_LOCKED;
			PDM_HWSTBY:  state_d = PDM_HWSTBY;
		endcase
		// re-entry after wake while standby select left set
		if (state_q == PDM_RUN && rearm_q && power_down_control_reg_q[PDM_STANDBY_SELECT_BIT]
				&& watchdog_counter_q == PDM_WDT_RELOCK)
			state_d = PDM_LOCKED;
		// locked standby ignores manual reset; a hardware request beats it outside sleep
		if (manual_reset && state_q != PDM_HWSTBY && state_q != PDM_LOCKED)
			state_d = PDM_RUN;
		if (hw_req && state_q != PDM_SLEEP)
			state_d = PDM_HWSTBY;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			state_q <= PDM_RUN;
		else
			state_q <= state_d;
	end

	// settling counter; stops when standby select is cleared after wake
	always_ff @(posedge ref_clk) begin
		if (reset)
			watchdog_counter_q <= PDM_WDT_RST;
		else if (wr_acc && paddr == PDM_WDT_ADDR && !pready)
			watchdog_counter_q <= pwdata[7:0];
		else if (state_q == PDM_SETTLE)
			watchdog_counter_q <= watchdog_counter_q + 8'h01;
		else if (state_q == PDM_RUN && rearm_q && power_down_control_reg_q[PDM_STANDBY_SELECT_BIT]
				&& watchdog_counter_q != PDM_WDT_RELOCK)
			watchdog_counter_q <= watchdog_counter_q + 8'h01;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			power_down_control_reg_q <= PDM_CTRL_RST;
			ctrl2_q                  <= PDM_CTRL_RST;
		end else if (manual_reset && state_q != PDM_HWSTBY && state_q != PDM_LOCKED) begin
			power_down_control_reg_q <= PDM_CTRL_RST;
			ctrl2_q                  <= PDM_CTRL_RST;
		end else if (wr_acc && !pready) begin
			if (paddr == PDM_CTRL_ADDR)
				power_down_control_reg_q <= pwdata[7:0] & PDM_CTRL_MASK;
			if (paddr == PDM_CTRL2_ADDR)
				ctrl2_q <= pwdata[7:0] & PDM_CTRL2_MASK;
		end
	end

	// re-lock watch arms only on a wake from standby, so a plain run with standby select set never locks
	always_ff @(posedge ref_clk) begin
		if (reset)
			rearm_q <= 1'b0;
		else if (state_q == PDM_SETTLE && state_d == PDM_RUN)
			rearm_q <= 1'b1;
		else if (state_q != PDM_RUN || !power_down_control_reg_q[PDM_STANDBY_SELECT_BIT])
			rearm_q <= 1'b0;
	end

	// event codes latched on a waking interrupt
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			event_code_reg_q   <= PDM_EVT_RST;
			event_code_reg_b_q <= PDM_EVT_RST;
		end else if (wake && (state_q == PDM_SLEEP || state_q == PDM_STANDBY)) begin
			event_code_reg_q <= wake_code;
			if (state_q == PDM_STANDBY)
				event_code_reg_b_q <= wake_code;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			irq_take <= 1'b0;
		else
			irq_take <= (state_q == PDM_SLEEP && wake) || (state_q == PDM_SETTLE && state_d == PDM_RUN);
	end

	// clock gating; standby and hw standby stop everything but the calendar clock
	assign stopped = (state_d == PDM_STANDBY || state_d == PDM_SETTLE || state_d == PDM_LOCKED || state_d == PDM_HWSTBY);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cpu_halt           <= 1'b0;
			bus_clk_en         <= 1'b1;
			periph_clk_en      <= 1'b1;
			timer_unit_clk_en  <= 1'b1;
			calendar_clk_en    <= 1'b1;
			serial0_clk_en     <= 1'b1;
			bus_ctrl_clk_en    <= 1'b1;
			timer_start_clr    <= 1'b0;
			calendar_access_ok <= 1'b1;
			serial0_reset      <= 1'b0;
		end else begin
			cpu_halt           <= state_d != PDM_RUN;
			bus_clk_en         <= !stopped;
			periph_clk_en      <= !stopped;
			timer_unit_clk_en  <= !stopped && !power_down_control_reg_q[PDM_TMU_BIT]
				&& !(state_d == PDM_HWSTBY);
			calendar_clk_en    <= !power_down_control_reg_q[PDM_RTC_BIT];
			serial0_clk_en     <= !stopped && !power_down_control_reg_q[PDM_SCI_BIT];
			bus_ctrl_clk_en    <= !stopped && !(state_d == PDM_SLEEP && ctrl2_q[PDM_BSC_BIT]);
			timer_start_clr    <= (state_d == PDM_STANDBY && state_q == PDM_RUN)
				|| power_down_control_reg_q[PDM_TMU_BIT];
			calendar_access_ok <= !power_down_control_reg_q[PDM_RTC_BIT];
			serial0_reset      <= power_down_control_reg_q[PDM_SCI_BIT];
		end
	end

	// state pins, registered on ref_clk
	always_comb begin
		unique case (state_d)
			PDM_RUN:     pins_d = PDM_PINS_NORMAL;
			PDM_SLEEP:   pins_d = refresh_active ? PDM_PINS_NORMAL : PDM_PINS_SLEEP;
			PDM_SETTLE:  pins_d = PDM_PINS_STANDBY_SELECT;
			default:     pins_d = PDM_PINS_STANDBY_SELECT;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			proc_state_hi <= PDM_PINS_RESET[1];
			proc_state_lo <= PDM_PINS_RESET[0];
		end else begin
			proc_state_hi <= pins_d[1];
			proc_state_lo <= pins_d[0];
		end
	end

	// apb: one wait state per access phase, unmapped reads zero with error
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & (paddr > PDM_WDT_ADDR || paddr[1:0] != 2'b00);
			prdata  <= 32'h0000_0000;
			if (rd_acc && !pready) begin
				unique case (paddr)
					PDM_CTRL_ADDR:  prdata <= {24'h0, power_down_control_reg_q};
					PDM_CTRL2_ADDR: prdata <= {24'h0, ctrl2_q};
					PDM_STAT_ADDR:  prdata <= {29'h0, state_q};
					PDM_EVT_ADDR:   prdata <= {20'h0, event_code_reg_q};
					PDM_EVTB_ADDR:  prdata <= {20'h0, event_code_reg_b_q};
					PDM_WDT_ADDR:   prdata <= {24'h0, watchdog_counter_q};
					default:        prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// checks
	property p_sleep_entry;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_RUN && sleep_exec && !power_down_control_reg_q[PDM_STANDBY_SELECT_BIT] && !hw_req && !manual_reset)
			|=> state_q == PDM_SLEEP ##1 (proc_state_hi || refresh_active || !cpu_halt);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	property p_standby_select_pins;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_STANDBY) |-> (!proc_state_hi && proc_state_lo && !bus_clk_en);
	endproperty
	a_standby_select_pins: assert property (p_standby_select_pins) else $error("standby pins wrong");

	property p_hw_sticky;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_HWSTBY) |=> state_q == PDM_HWSTBY;
	endproperty
	a_hw_sticky: assert property (p_hw_sticky) else $error("hw standby left");

	property p_lock;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_LOCKED) |=> (state_q == PDM_LOCKED || state_q == PDM_HWSTBY);
	endproperty
	a_lock: assert property (p_lock) else $error("locked standby left");

	property p_tmu_gate;
		@(posedge ref_clk) disable iff (reset)
		power_down_control_reg_q[PDM_TMU_BIT] |=> !timer_unit_clk_en;
	endproperty
	a_tmu_gate: assert property (p_tmu_gate) else $error("timer clock not gated");

	property p_rtc_access;
		@(posedge ref_clk) disable iff (reset)
		$rose(power_down_control_reg_q[PDM_RTC_BIT]) |=> !calendar_access_ok && !calendar_clk_en;
	endproperty
	a_rtc_access: assert property (p_rtc_access) else $error("calendar access open");

	property p_hwreq;
		@(posedge ref_clk) disable iff (reset)
		(hw_req && state_q != PDM_SLEEP) |=> state_q == PDM_HWSTBY;
	endproperty
	a_hwreq: assert property (p_hwreq) else $error("hw request missed");

	property p_sleep_wake;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_SLEEP && nmi_req && !hw_req) |=> state_q == PDM_RUN && event_code_reg_q == PDM_EVT_NMI && irq_take;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake wrong");

	property p_refresh_pins;
		@(posedge ref_clk) disable iff (reset)
		(state_q == PDM_SLEEP && state_d == PDM_SLEEP && refresh_active) |=> !proc_state_hi && !proc_state_lo;
	endproperty
	a_refresh_pins: assert property (p_refresh_pins) else $error("refresh pins wrong");
endmodule : pdm_ctrl

// *** rtl/pdm_pkg.sv ***
// constants and types for the power-down mode controller
// What this block does
// - sleep instruction with standby select 0 halts cpu, keeps registers, enters sleep
// - in sleep, peripherals keep running and bus clock pin keeps toggling
// - state pins: reset HH, sleep HL, standby LH, normal LL
// - during refresh in sleep both state pins are low
// - sleep ends on nmi, level, peripheral interrupt or reset, ignoring block bit
// - waking interrupt runs exception handling and loads event code register
// - sleep with standby select 1 halts cpu, clocks, peripherals and bus clock pin
// - standby entry clears timer start register; other registers kept
// - after wake, wait settling time, restore clocks, pins low, load both codes
// - if standby select stays set, watchdog counter reaching 80h re-enters locked standby
// - maskable wake only when request level exceeds mask level
// - level, external and port wakes need calendar clock; peripherals limited similarly
// - power-on reset ends standby, manual reset ends all but locked and hardware standby; bus clock keeps being driven
// - module stop bit gates that module's clock; serial pins reset
// - timer stop clears start register; calendar stop blocks register access and gates the calendar clock
// - module standby ends when stop bits clear or on reset
// - hw standby request low halts all but calendar clock modules, refuses irqs; the code ignores the request while in sleep
// - hw standby request sampled on 32.768 khz, needs two consecutive lows
// - hardware standby is left only by power-on reset
package pdm_pkg;
	localparam logic [7:0] PDM_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] PDM_CTRL2_ADDR   = 8'h04;
	localparam logic [7:0] PDM_STAT_ADDR    = 8'h08;
	localparam logic [7:0] PDM_EVT_ADDR     = 8'h0c;
	localparam logic [7:0] PDM_EVTB_ADDR    = 8'h10;
	localparam logic [7:0] PDM_WDT_ADDR     = 8'h14;
	localparam int         PDM_STANDBY_SELECT_BIT     = 7;
	localparam int         PDM_TMU_BIT      = 2;
	localparam int         PDM_RTC_BIT      = 1;
	localparam int         PDM_SCI_BIT      = 0;
	localparam int         PDM_BSC_BIT      = 7;
	localparam logic [7:0] PDM_CTRL_RST     = 8'h00;
	localparam logic [7:0] PDM_CTRL_MASK    = 8'h87;
	localparam logic [7:0] PDM_CTRL2_MASK   = 8'hbf;
	localparam logic [7:0] PDM_WDT_RST      = 8'h00;
	localparam logic [7:0] PDM_WDT_RELOCK   = 8'h80;
	localparam logic [7:0] PDM_WDT_TOP      = 8'hff;
	localparam logic [11:0] PDM_EVT_RST     = 12'h000;
	localparam logic [11:0] PDM_EVT_NMI     = 12'h1c0;
	localparam logic [1:0] PDM_PINS_RESET   = 2'b11;
	localparam logic [1:0] PDM_PINS_SLEEP   = 2'b10;
	localparam logic [1:0] PDM_PINS_STANDBY_SELECT    = 2'b01;
	localparam logic [1:0] PDM_PINS_NORMAL  = 2'b00;
	localparam int         PDM_SUB_LOWS     = 2;
	typedef enum logic [2:0] {PDM_RUN, PDM_SLEEP, PDM_STANDBY, PDM_SETTLE, PDM_LOCKED, PDM_HWSTBY} pdm_state_t;
endpackage : pdm_pkg

// *** tb/pdm_far_side.sv ***
// far-side system model: standby request pin, sub-clock strobe, state-pin watcher
`timescale 1ns/100ps
module pdm_far_side #(
	parameter int TICK_DIV = 16
) (
	// clock
	input  wire logic ref_clk,
	// bench control
	input  wire logic want_low,
	// state pins
	input  wire logic proc_state_hi,
	input  wire logic proc_state_lo,
	// to device; standby_select_seen to the bench
	output logic      sub_clk_tick = 1'b0,
	output logic      hw_standby_request_n = 1'b1,
	output logic      standby_select_seen = 1'b0
);
	int div = 0;

	// sub-clock scaled down; the true rate would stretch the run far too long
	always @(posedge ref_clk) begin
		div <= (div == TICK_DIV - 1) ? 0 : div + 1;
		sub_clk_tick <= (div == 0);
		hw_standby_request_n <= !want_low;
	end

	// clock changes and wake requests only once standby shows on the pins
	always @(posedge ref_clk) begin
		standby_select_seen <= !proc_state_hi && proc_state_lo;
	end
endmodule : pdm_far_side

// *** tb/tb_top.sv ***
// self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
	import pdm_pkg::*;
	logic        ref_clk, reset, manual_reset, psel, penable, pwrite, sleep_exec, block_bit, nmi_req, port_irq;
	logic        periph_irq, rtc_irq, rtc_in_use, refresh_active, want_low, sub_clk_tick, hw_standby_request_n;
	logic        pready, pslverr, err, cpu_halt, irq_take, bus_clk_en, periph_clk_en, timer_unit_clk_en;
	logic        calendar_clk_en, serial0_clk_en, bus_ctrl_clk_en, timer_start_clr, calendar_access_ok;
	logic        serial0_reset, proc_state_hi, proc_state_lo, standby_select_seen, clr_seen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  irq_mask_level, encoded_level_irq, periph_level;
	logic [11:0] periph_code;
	int          err_count, samples_checked, cycles, seed, lvl, pc;
	int          code_q[$];

	pdm_ctrl DUT (.*);
	pdm_far_side far (.ref_clk(ref_clk), .want_low(want_low), .proc_state_hi(proc_state_hi),
		.proc_state_lo(proc_state_lo), .sub_clk_tick(sub_clk_tick),
		.hw_standby_request_n(hw_standby_request_n), .standby_select_seen(standby_select_seen));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			print_verdict;
		end
	end

	// caught as it rises, so a one-cycle clear is still seen after it ends
	always @(posedge timer_start_clr) clr_seen <= 1'b1;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [11:0] e);
		apb(1'b0, a, 32'h0);
		`CHK({err, rd[11:0]}, {1'b0, e}, "register read")
	endtask : rdchk

	task automatic wait_pins(input logic [1:0] p, input int lim);
		int n;
		n = 0;
		while ({proc_state_hi, proc_state_lo} !== p && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK({proc_state_hi, proc_state_lo}, p, "state pins")
	endtask : wait_pins

	task automatic do_sleep;
		@(posedge ref_clk);
		sleep_exec <= 1'b1;
		@(posedge ref_clk);
		sleep_exec <= 1'b0;
	endtask : do_sleep

	task automatic por;
		@(posedge ref_clk);
		reset <= 1'b1;
		want_low <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
	endtask : por

	initial begin
		seed = 32'h6573;
		{reset, manual_reset, psel, penable, pwrite, sleep_exec, nmi_req, port_irq, periph_irq, rtc_irq} = '0;
		{rtc_in_use, refresh_active, want_low, clr_seen} = '0;
		{paddr, pwdata, irq_mask_level, encoded_level_irq, periph_level, periph_code} = '0;
		block_bit = 1'b1; // context saving left to the program
		reset = 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK({proc_state_hi, proc_state_lo}, PDM_PINS_RESET, "reset pins")
		reset <= 1'b0;
		wait_pins(PDM_PINS_NORMAL, 3);
		rdchk(PDM_CTRL_ADDR, 12'h0);
		rdchk(PDM_WDT_ADDR, 12'h0);
		clr_seen = 1'b0;
		apb(1'b1, PDM_CTRL_ADDR, 32'h7f);
		rdchk(PDM_CTRL_ADDR, 12'h007);
		`CHK({timer_unit_clk_en, calendar_clk_en, serial0_clk_en, calendar_access_ok, serial0_reset, clr_seen}, 6'h03, "stop")
		apb(1'b1, PDM_CTRL_ADDR, 32'h0);
		rdchk(PDM_CTRL_ADDR, 12'h0);
		`CHK({timer_unit_clk_en, calendar_clk_en, serial0_clk_en, calendar_access_ok, serial0_reset}, 5'h1e, "run")
		apb(1'b0, 8'h18, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
		$display("test registers done");
		apb(1'b1, PDM_CTRL2_ADDR, 32'h80);
		for (int i = 0; i < 4; i++) begin
			lvl = 1 + {$random(seed)} % 15;
			pc = {$random(seed)} % 4096;
			do_sleep;
			wait_pins(PDM_PINS_SLEEP, 3);
			if (i == 0) begin
				`CHK({cpu_halt, bus_clk_en, periph_clk_en, bus_ctrl_clk_en}, 4'he, "sleep clocks")
				refresh_active <= 1'b1;
				wait_pins(PDM_PINS_NORMAL, 3);
				refresh_active <= 1'b0;
				wait_pins(PDM_PINS_SLEEP, 3);
			end
			periph_level <= lvl[3:0];
			periph_code <= pc[11:0];
			if (i == 0) nmi_req <= 1'b1;
			else if (i == 3) periph_irq <= 1'b1;
			else encoded_level_irq <= lvl[3:0];
			code_q.push_back(i == 0 ? 'h1c0 : i == 3 ? pc : 'h200 | (lvl << 4));
			wait_pins(PDM_PINS_NORMAL, 4);
			{nmi_req, periph_irq, encoded_level_irq} <= '0;
			`CHK({cpu_halt, irq_take}, 2'b01, "cpu resumes")
			rdchk(PDM_EVT_ADDR, 12'(code_q.pop_front()));
		end
		apb(1'b1, PDM_CTRL2_ADDR, 32'h0);
		$display("test sleep done");
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, PDM_WDT_ADDR, 32'hf0);
			apb(1'b1, PDM_CTRL_ADDR, 32'h80);
			clr_seen = 1'b0;
			do_sleep;
			wait_pins(PDM_PINS_STANDBY_SELECT, 3);
			`CHK({cpu_halt, bus_clk_en, periph_clk_en, clr_seen}, 4'h9, "standby entry")
			irq_mask_level <= 4'h9;
			encoded_level_irq <= 4'h9;
			rtc_in_use <= 1'b1;
			repeat (40) @(posedge ref_clk);
			encoded_level_irq <= 4'ha;
			rtc_in_use <= 1'b0;
			repeat (40) @(posedge ref_clk);
			`CHK({proc_state_hi, proc_state_lo, standby_select_seen}, {PDM_PINS_STANDBY_SELECT, 1'b1}, "no wake")
			rtc_in_use <= 1'b1;
			code_q.push_back('h2a0);
			wait_pins(PDM_PINS_NORMAL, 600);
			`CHK(irq_take, 1'b1, "standby wake handling")
			encoded_level_irq <= 4'h0;
			rdchk(PDM_EVT_ADDR, 12'(code_q[0]));
			rdchk(PDM_EVTB_ADDR, 12'(code_q.pop_front()));
			if (k == 0) begin
				apb(1'b1, PDM_CTRL_ADDR, 32'h0);
				repeat (600) @(posedge ref_clk);
				`CHK({proc_state_hi, proc_state_lo}, PDM_PINS_NORMAL, "counter stopped")
			end else begin
				wait_pins(PDM_PINS_STANDBY_SELECT, 900);
				nmi_req <= 1'b1;
				manual_reset <= 1'b1;
				repeat (20) @(posedge ref_clk);
				`CHK({proc_state_hi, proc_state_lo}, PDM_PINS_STANDBY_SELECT, "locked")
				nmi_req <= 1'b0;
				manual_reset <= 1'b0;
				irq_mask_level <= 4'h0;
				por;
				`CHK(bus_clk_en, 1'b1, "bus clock in reset")
				wait_pins(PDM_PINS_NORMAL, 4);
			end
		end
		$display("test standby done");
		want_low <= 1'b1;
		repeat (10) @(posedge ref_clk);
		want_low <= 1'b0;
		repeat (40) @(posedge ref_clk);
		`CHK(periph_clk_en, 1'b1, "single low sample")
		want_low <= 1'b1;
		repeat (50) @(posedge ref_clk);
		`CHK({periph_clk_en, calendar_clk_en}, 2'b01, "hw standby")
		nmi_req <= 1'b1;
		manual_reset <= 1'b1;
		repeat (20) @(posedge ref_clk);
		`CHK({periph_clk_en, irq_take}, 2'b00, "refused wake")
		{nmi_req, manual_reset} <= 2'b00;
		por;
		wait_pins(PDM_PINS_NORMAL, 4);
		$display("test hw standby done");
		print_verdict;
	end
endmodule : tb_top
